// ### pin_func_decode.sv
`timescale 1ns/1ns
`include "pin_func_params.svh"
// Function
// - Code 0x47 drives loop0 profile bit 2
// - Code 0x59 drives channel 0 mute-all
// - Code 0x5A drives channel 0 reset-all
// - Code 0x5B drives channel 0 burst request
// - Codes 0x50-0x58 drive channel 0 output controls
// - Code 0x60 drives loop1 power-down
// - Codes 0x61/0x62 force loop1 freerun/holdover
// - Code 0x63 clears loop1 tuning history
// - Code 0x64 requests loop1 divider sync
// - Codes 0x65-0x67 drive loop1 profile bits
// - Codes 0x70-0x75 drive channel 1 output controls
// - Codes 0x76-0x78 drive channel 1 group controls
// - Status 0x50-0x53 show loop1 lock flags
// - Status 0x54 shows loop1 active, OR
// - Status 0x55-0x57 show loop1 mode flags
// - Status 0x58, 0x5A, 0x5B, 0x5F, 0x60 show loop1 history flags
// - Status 0x62 shows OR of slew enables
// - Status 0x63 shows OR of phase errors
// - Status 0x70-0x73 pass auxiliary oscillator clocks
// - Status 0x74/0x75 show auxiliary loop flags
// - Status 0x78-0x7A show measurement events
module pin_func_decode (
	input  wire logic                      clk_in,
	input  wire logic                      rstn_in,
	input  wire logic                      ce_in,
	input  wire pin_func_pkg::pin_vec_t    pin_mode_in,
	input  wire pin_func_pkg::pin_codes_t  pin_code_in,
	input  wire pin_func_pkg::pin_vec_t    pin_level_in,
	input  wire pin_func_pkg::ctrl_vec_t   ctrl_sw_in,
	input  wire logic [3:0]                loop1_lock_in,
	input  wire logic [5:0]                loop1_active_in,
	input  wire logic [2:0]                loop1_mode_in,
	input  wire logic [5:0]                loop1_hist_in,
	input  wire logic [3:0]                dist1_slew_in,
	input  wire logic [3:0]                dist1_err_in,
	input  wire logic [3:0]                aux_clk_in,
	input  wire logic [1:0]                aux_loop_in,
	input  wire logic [2:0]                meas_event_in,
	output logic [`CTRL_BITS-1:0]          ctrl_out,
	output logic [`MFP_PINS-1:0]           pin_drive_out,
	output logic [`MFP_PINS-1:0]           pin_oe_out
);
	// ==========================================
	// Reset release
	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// ==========================================
	// Pin level synchroniser
	// Pins come from board logic with no relation to our clock
	pin_func_pkg::pin_vec_t sync1_reg;
	pin_func_pkg::pin_vec_t sync1_next;
	pin_func_pkg::pin_vec_t sync2_reg;
	pin_func_pkg::pin_vec_t sync2_next;

	always_comb begin
		sync1_next = ce_in ? pin_level_in : sync1_reg;
		sync2_next = ce_in ? sync1_reg : sync2_reg;
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= `PIN_RST;
			sync2_reg <= `PIN_RST;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
		end
	end

	// ==========================================
	// Decoders
	pin_link_if link ();

	assign link.code      = pin_code_in;
	assign link.is_status = pin_mode_in;
	assign link.level     = sync2_reg;
	assign link.src       = '{lock: loop1_lock_in, active: loop1_active_in,
	                          mode: loop1_mode_in, hist: loop1_hist_in,
	                          slew: dist1_slew_in, err: dist1_err_in,
	                          aux_clk: aux_clk_in, aux_loop: aux_loop_in,
	                          evt: meas_event_in};

	ctrl_map u_ctrl_map (
		.link (link.mapper)
	);

	status_mux u_status_mux (
		.link (link.selector)
	);

	// ==========================================
	// Output registers
	// A mapped pin overrides the software value, so it acts as that bit's writer.
	// Software reaches ctrl_out one cycle after it changes, a pin three.
	pin_func_pkg::ctrl_vec_t ctrl_reg;
	pin_func_pkg::ctrl_vec_t ctrl_next;
	pin_func_pkg::pin_vec_t  drive_reg;
	pin_func_pkg::pin_vec_t  drive_next;
	pin_func_pkg::pin_vec_t  oe_reg;
	pin_func_pkg::pin_vec_t  oe_next;

	always_comb begin
		ctrl_next  = ctrl_reg;
		drive_next = drive_reg;
		oe_next    = oe_reg;
		if (ce_in) begin
			ctrl_next  = (link.pin_hit & link.pin_val) | (~link.pin_hit & ctrl_sw_in);
			drive_next = link.status_val;
			oe_next    = pin_mode_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg  <= `CTRL_RST;
			drive_reg <= `PIN_RST;
			oe_reg    <= `PIN_RST;
		end else begin
			ctrl_reg  <= ctrl_next;
			drive_reg <= drive_next;
			oe_reg    <= oe_next;
		end
	end

	assign ctrl_out      = ctrl_reg;
	assign pin_drive_out = drive_reg;
	assign pin_oe_out    = oe_reg;

	// ==========================================
	// Assertion helpers, watching pin 0
	logic [1:0]               ce_cnt_reg;
	logic [1:0]               ce_cnt_next;
	pin_func_pkg::func_code_t code0_reg;
	pin_func_pkg::func_code_t code0_next;
	logic                     mode0_reg;
	logic                     mode0_next;
	logic                     others_status;
	logic                     ctl0_ok;
	logic                     sta0_ok;

	always_comb begin
		ce_cnt_next = ce_in ? ((ce_cnt_reg == 2'h3) ? 2'h3 : ce_cnt_reg + 2'h1) : 2'h0;
		code0_next  = pin_code_in[0];
		mode0_next  = pin_mode_in[0];
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ce_cnt_reg <= 2'h0;
			code0_reg  <= 7'h00;
			mode0_reg  <= 1'b0;
		end else begin
			ce_cnt_reg <= ce_cnt_next;
			code0_reg  <= code0_next;
			mode0_reg  <= mode0_next;
		end
	end

	assign others_status = &pin_mode_in[`MFP_PINS-1:1];
	assign ctl0_ok       = (ce_cnt_reg == 2'h3) && !mode0_reg;
	assign sta0_ok       = (ce_cnt_reg != 2'h0) && mode0_reg;

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n);

	property p_ctrl_high(logic [6:0] fc, logic dst);
		(ctl0_ok && code0_reg == fc && $past(pin_level_in[0], 3)) |-> dst;
	endproperty

	a_loop0_prof_bit: assert property (p_ctrl_high(`FC_LOOP0_PROF2, ctrl_out[`CI_LOOP0_PROF2]))
		else $error("Profile bit not driven by pin");
	a_ch0_mute_all: assert property (ctl0_ok && code0_reg == 7'h59
		&& $past(others_status) |-> ctrl_out[`CI_CH0_MUTE_ALL] == $past(pin_level_in[0], 3))
		else $error("Channel 0 mute-all not following pin");
	a_ch0_reset_all: assert property (p_ctrl_high(7'h5a, ctrl_out[`CI_CH0_RST_ALL]))
		else $error("Channel 0 reset-all not driven");
	a_ch0_burst_req: assert property (p_ctrl_high(`FC_CH0_LAST, ctrl_out[`CI_CH0_BURST]))
		else $error("Channel 0 burst request not driven");
	a_ch0_out_ctrl: assert property (p_ctrl_high(7'h56, ctrl_out[7]))
		else $error("Channel 0 output mute not driven");
	a_loop1_pwr_down: assert property (p_ctrl_high(`FC_LOOP1_FIRST, ctrl_out[`CI_LOOP1_PD]))
		else $error("Power-down not driven");
	a_force_holdover: assert property (p_ctrl_high(7'h62, ctrl_out[`CI_HOLDOVER]))
		else $error("Forced holdover not driven");
	a_hist_clear: assert property (p_ctrl_high(7'h63, ctrl_out[`CI_HIST_CLR]))
		else $error("History clear not driven");
	a_div_sync_req: assert property (p_ctrl_high(7'h64, ctrl_out[`CI_DIV_SYNC]))
		else $error("Divider sync not driven");
	a_loop1_prof_bits: assert property (p_ctrl_high(`FC_LOOP1_LAST, ctrl_out[20]))
		else $error("Loop 1 profile bit 2 not driven");
	a_ch1_out_ctrl: assert property (p_ctrl_high(7'h75, ctrl_out[26]))
		else $error("Channel 1 pair reset not driven");
	a_ch1_group_ctrl: assert property (p_ctrl_high(`FC_CH1_LAST, ctrl_out[`CI_CH1_BURST]))
		else $error("Channel 1 burst request not driven");
	a_ch0_mute_a: assert property (p_ctrl_high(`FC_CH0_FIRST, ctrl_out[`CI_CH0_BASE]))
		else $error("Channel 0 output A mute not driven");
	a_force_freerun: assert property (p_ctrl_high(7'h61, ctrl_out[`CI_FREERUN]))
		else $error("Forced freerun not driven");
	a_loop1_prof_b0: assert property (p_ctrl_high(7'h65, ctrl_out[`CI_PROF1_B0]))
		else $error("Loop 1 profile bit 0 not driven");
	a_pwr_down_follow: assert property (ctl0_ok && code0_reg == `FC_LOOP1_FIRST
		&& $past(others_status) |-> ctrl_out[`CI_LOOP1_PD] == $past(pin_level_in[0], 3))
		else $error("Power-down not following pin");
	// A change two samples back must not yet have reached the bit
	a_sync_lag: assert property (ctl0_ok && code0_reg == 7'h61 && $past(others_status)
		&& $past(pin_level_in[0], 3) != $past(pin_level_in[0], 2)
		|-> ctrl_out[`CI_FREERUN] == $past(pin_level_in[0], 3))
		else $error("Pin reached control bit with wrong delay");
	// Clock enable low must hold every output, not just the synchroniser
	a_frozen_outputs: assert property (!$past(ce_in)
		|-> $stable(ctrl_out) && $stable(pin_drive_out) && $stable(pin_oe_out))
		else $error("Outputs moved while clock enable was low");
	a_oe_tracks_mode: assert property (ce_cnt_reg != 2'h0
		|-> pin_oe_out == $past(pin_mode_in))
		else $error("Pin output enable not following mode");
	a_status_no_ctrl: assert property (sta0_ok && $past(others_status)
		|-> ctrl_out == $past(ctrl_sw_in))
		else $error("Status pin changed a control bit");

	// ==========================================
	// Status path assertions
	a_phase_lock_status: assert property (sta0_ok && code0_reg == `SC_PH_LOCK
		|-> pin_drive_out[0] == $past(loop1_lock_in[0]))
		else $error("Phase lock status wrong on pin");
	a_lock_status: assert property (sta0_ok && code0_reg == `SC_CAL
		|-> pin_drive_out[0] == $past(loop1_lock_in[3]))
		else $error("Calibration status wrong on pin");
	a_active_status: assert property (sta0_ok && code0_reg == `SC_ACTIVE
		|-> pin_drive_out[0] == $past(|loop1_active_in))
		else $error("Active status wrong on pin");
	a_freerun_status: assert property (sta0_ok && code0_reg == `SC_FREERUN
		|-> pin_drive_out[0] == $past(loop1_mode_in[0]))
		else $error("Freerun status wrong on pin");
	a_mode_status: assert property (sta0_ok && code0_reg == `SC_SWITCH
		|-> pin_drive_out[0] == $past(loop1_mode_in[2]))
		else $error("Switching status wrong on pin");
	a_hist_valid_status: assert property (sta0_ok && code0_reg == `SC_HIST_VALID
		|-> pin_drive_out[0] == $past(loop1_hist_in[0]))
		else $error("History valid status wrong on pin");
	a_clamp_status: assert property (sta0_ok && code0_reg == `SC_CLAMP
		|-> pin_drive_out[0] == $past(loop1_hist_in[1]))
		else $error("Clamp status wrong on pin");
	a_hist_status: assert property (sta0_ok && code0_reg == `SC_FAST_ACT
		|-> pin_drive_out[0] == $past(loop1_hist_in[4]))
		else $error("Fast acquisition status wrong on pin");
	a_fast_done_status: assert property (sta0_ok && code0_reg == `SC_FAST_DONE
		|-> pin_drive_out[0] == $past(loop1_hist_in[5]))
		else $error("Fast acquisition done wrong on pin");
	a_slew_status: assert property (sta0_ok && code0_reg == `SC_SLEW_EN
		|-> pin_drive_out[0] == $past(|dist1_slew_in))
		else $error("Slew enable OR wrong on pin");
	a_err_status: assert property (sta0_ok && code0_reg == `SC_PHASE_ERR
		|-> pin_drive_out[0] == $past(|dist1_err_in))
		else $error("Phase error OR wrong on pin");
	a_aux_clk_out: assert property (sta0_ok && code0_reg == `SC_AUX1_TAG
		|-> pin_drive_out[0] == $past(aux_clk_in[3]))
		else $error("Auxiliary clock not on pin");
	a_aux_lock_status: assert property (sta0_ok && code0_reg == `SC_AUX_LOCK
		|-> pin_drive_out[0] == $past(aux_loop_in[0]))
		else $error("Auxiliary lock wrong on pin");
	a_aux_loop_status: assert property (sta0_ok && code0_reg == `SC_AUX_FAULT
		|-> pin_drive_out[0] == $past(aux_loop_in[1]))
		else $error("Auxiliary fault wrong on pin");
	a_ts0_status: assert property (sta0_ok && code0_reg == `SC_TS0
		|-> pin_drive_out[0] == $past(meas_event_in[0]))
		else $error("Timestamp 0 event wrong on pin");
	a_event_status: assert property (sta0_ok && code0_reg == `SC_SKEW
		|-> pin_drive_out[0] == $past(meas_event_in[2]))
		else $error("Skew event wrong on pin");
	a_unused_status: assert property (sta0_ok && code0_reg == `FC_UNUSED
		|-> !pin_drive_out[0] && pin_oe_out[0])
		else $error("Unassigned status pin not held low");
	a_unused_ctrl: assert property (ce_cnt_reg != 2'h0 && !mode0_reg
		&& code0_reg == `FC_UNUSED && $past(others_status) |-> ctrl_out == $past(ctrl_sw_in))
		else $error("Unassigned control pin changed a bit");

	c_pin_ctrl: cover property (ctl0_ok && code0_reg == `FC_LOOP1_FIRST && ctrl_out[`CI_LOOP1_PD]);
	c_pin_status: cover property (sta0_ok && code0_reg == `SC_PH_LOCK && pin_drive_out[0]);
	c_event_pin: cover property (sta0_ok && code0_reg == `SC_TS0 && pin_drive_out[0]);
	c_unused_status: cover property (sta0_ok && code0_reg == `FC_UNUSED && pin_oe_out[0]);
	c_freeze: cover property (!ce_in [*3] ##1 ce_in);
endmodule

// ### pin_func_params.svh
`ifndef PIN_FUNC_PARAMS_SVH
`define PIN_FUNC_PARAMS_SVH

// ==========================================
// Widths
`define MFP_PINS        4
`define CODE_W          7
`define CTRL_BITS       30

// ==========================================
// Control function codes
`define FC_LOOP0_PROF2  7'h47
`define FC_CH0_FIRST    7'h50
`define FC_CH0_LAST     7'h5b
`define FC_LOOP1_FIRST  7'h60
`define FC_LOOP1_LAST   7'h67
`define FC_CH1_FIRST    7'h70
`define FC_CH1_LAST     7'h78
`define FC_UNUSED       7'h48

// ==========================================
// Control vector bit positions
`define CI_LOOP0_PROF2  0
`define CI_CH0_BASE     1
`define CI_CH0_MUTE_ALL 10
`define CI_CH0_RST_ALL  11
`define CI_CH0_BURST    12
`define CI_LOOP1_BASE   13
`define CI_LOOP1_PD     13
`define CI_FREERUN      14
`define CI_HOLDOVER     15
`define CI_HIST_CLR     16
`define CI_DIV_SYNC     17
`define CI_PROF1_B0     18
`define CI_CH1_BASE     21
`define CI_CH1_MUTE_ALL 27
`define CI_CH1_RST_ALL  28
`define CI_CH1_BURST    29

// ==========================================
// Status function codes
`define SC_PH_LOCK      7'h50
`define SC_FR_LOCK      7'h51
`define SC_AN_LOCK      7'h52
`define SC_CAL          7'h53
`define SC_ACTIVE       7'h54
`define SC_FREERUN      7'h55
`define SC_HOLDOVER     7'h56
`define SC_SWITCH       7'h57
`define SC_HIST_VALID   7'h58
`define SC_CLAMP        7'h5a
`define SC_SLEW_LIM     7'h5b
`define SC_FAST_ACT     7'h5f
`define SC_FAST_DONE    7'h60
`define SC_SLEW_EN      7'h62
`define SC_PHASE_ERR    7'h63
`define SC_AUX0_FUND    7'h70
`define SC_AUX0_TAG     7'h71
`define SC_AUX1_FUND    7'h72
`define SC_AUX1_TAG     7'h73
`define SC_AUX_LOCK     7'h74
`define SC_AUX_FAULT    7'h75
`define SC_TS0          7'h78
`define SC_TS1          7'h79
`define SC_SKEW         7'h7a

// ==========================================
// Reset values
`define CTRL_RST        30'h0
`define PIN_RST         4'h0

`endif

// ### pin_func_pkg.sv
`include "pin_func_params.svh"
package pin_func_pkg;
	typedef logic [`CODE_W-1:0]                 func_code_t;
	typedef logic [`MFP_PINS-1:0][`CODE_W-1:0]  pin_codes_t;
	typedef logic [`CTRL_BITS-1:0]              ctrl_vec_t;
	typedef logic [`MFP_PINS-1:0]               pin_vec_t;
	typedef struct packed {
		logic [3:0] lock;
		logic [5:0] active;
		logic [2:0] mode;
		logic [5:0] hist;
		logic [3:0] slew;
		logic [3:0] err;
		logic [3:0] aux_clk;
		logic [1:0] aux_loop;
		logic [2:0] evt;
	} status_src_t;
endpackage

// ### pin_link_if.sv
`timescale 1ns/1ns
`include "pin_func_params.svh"
interface pin_link_if;
	pin_func_pkg::pin_codes_t  code;
	pin_func_pkg::pin_vec_t    is_status;
	pin_func_pkg::pin_vec_t    level;
	pin_func_pkg::status_src_t src;
	pin_func_pkg::ctrl_vec_t   pin_hit;
	pin_func_pkg::ctrl_vec_t   pin_val;
	pin_func_pkg::pin_vec_t    status_val;
	modport top (output code, is_status, level, src, input pin_hit, pin_val, status_val);
	modport mapper (input code, is_status, level, output pin_hit, pin_val);
	modport selector (input code, is_status, src, output status_val);
endinterface

// ### ctrl_map.sv
`timescale 1ns/1ns
`include "pin_func_params.svh"
module ctrl_map (
	pin_link_if.mapper link
);
	// ==========================================
	// Code to destination bit
	function automatic pin_func_pkg::ctrl_vec_t ctrl_dest(input pin_func_pkg::func_code_t code);
		int c;
		ctrl_dest = '0;
		c = int'(code);
		for (int b = 0; b < `CTRL_BITS; b++) begin
			if (c == `FC_LOOP0_PROF2 && b == `CI_LOOP0_PROF2) begin
				ctrl_dest[b] = 1'b1;
			end
			// Outputs, pair resets, mute-all, reset-all, burst in code order
			if (c >= `FC_CH0_FIRST && c <= `FC_CH0_LAST && b == c - `FC_CH0_FIRST + `CI_CH0_BASE) begin
				ctrl_dest[b] = 1'b1;
			end
			if (c >= `FC_LOOP1_FIRST && c <= `FC_LOOP1_LAST && b == c - `FC_LOOP1_FIRST + `CI_LOOP1_BASE) begin
				ctrl_dest[b] = 1'b1;
			end
			if (c >= `FC_CH1_FIRST && c <= `FC_CH1_LAST && b == c - `FC_CH1_FIRST + `CI_CH1_BASE) begin
				ctrl_dest[b] = 1'b1;
			end
		end
	endfunction

	pin_func_pkg::ctrl_vec_t dest [`MFP_PINS];

	// ==========================================
	// Per pin decode, status pins and unassigned codes reach nothing
	generate
		for (genvar i = 0; i < `MFP_PINS; i++) begin : g_pin
			assign dest[i] = link.is_status[i] ? '0 : ctrl_dest(link.code[i]);
		end
	endgenerate

	// Two pins on one bit combine as OR
	always_comb begin
		link.pin_hit = '0;
		link.pin_val = '0;
		for (int i = 0; i < `MFP_PINS; i++) begin
			link.pin_hit = link.pin_hit | dest[i];
			link.pin_val = link.pin_val | (dest[i] & {`CTRL_BITS{link.level[i]}});
		end
	end
endmodule

// ### status_mux.sv
`timescale 1ns/1ns
`include "pin_func_params.svh"
module status_mux (
	pin_link_if.selector link
);
	// ==========================================
	// Code to status source
	function automatic logic stat_bit(input pin_func_pkg::func_code_t code,
	                                  input pin_func_pkg::status_src_t s);
		case (code)
			`SC_PH_LOCK:    stat_bit = s.lock[0];
			`SC_FR_LOCK:    stat_bit = s.lock[1];
			`SC_AN_LOCK:    stat_bit = s.lock[2];
			`SC_CAL:        stat_bit = s.lock[3];
			`SC_ACTIVE:     stat_bit = |s.active;
			`SC_FREERUN:    stat_bit = s.mode[0];
			`SC_HOLDOVER:   stat_bit = s.mode[1];
			`SC_SWITCH:     stat_bit = s.mode[2];
			`SC_HIST_VALID: stat_bit = s.hist[0];
			`SC_CLAMP:      stat_bit = s.hist[1];
			`SC_SLEW_LIM:   stat_bit = s.hist[2];
			`SC_FAST_ACT:   stat_bit = s.hist[4];
			`SC_FAST_DONE:  stat_bit = s.hist[5];
			`SC_SLEW_EN:    stat_bit = |s.slew;
			`SC_PHASE_ERR:  stat_bit = |s.err;
			`SC_AUX0_FUND:  stat_bit = s.aux_clk[0];
			`SC_AUX0_TAG:   stat_bit = s.aux_clk[1];
			`SC_AUX1_FUND:  stat_bit = s.aux_clk[2];
			`SC_AUX1_TAG:   stat_bit = s.aux_clk[3];
			`SC_AUX_LOCK:   stat_bit = s.aux_loop[0];
			`SC_AUX_FAULT:  stat_bit = s.aux_loop[1];
			`SC_TS0:        stat_bit = s.evt[0];
			`SC_TS1:        stat_bit = s.evt[1];
			`SC_SKEW:       stat_bit = s.evt[2];
			default:        stat_bit = 1'b0;
		endcase
	endfunction

	always_comb begin
		link.status_val = '0;
		for (int i = 0; i < `MFP_PINS; i++) begin
			link.status_val[i] = link.is_status[i] & stat_bit(link.code[i], link.src);
		end
	end
endmodule

// ### board_model.sv
`timescale 1ns/1ns
`include "pin_func_params.svh"
// ==========================================
// Board logic on the multifunction pins
// The board drives a pin only while the device has it as an input, so the
// wire level is resolved from the device's enable alone and never fights the device.
module board_model (
	input  wire pin_func_pkg::pin_vec_t want_in,
	input  wire pin_func_pkg::pin_vec_t drive_in,
	input  wire pin_func_pkg::pin_vec_t oe_in,
	output pin_func_pkg::pin_vec_t      wire_out
);
	always_comb begin
		for (int i = 0; i < `MFP_PINS; i++) begin
			wire_out[i] = oe_in[i] ? drive_in[i] : want_in[i];
		end
	end
endmodule

// ### tb.sv
`timescale 1ns/1ns
`include "pin_func_params.svh"
module tb;
	logic                      clk_in;
	logic                      rstn_in;
	logic                      ce_in;
	pin_func_pkg::pin_vec_t    pin_mode;
	pin_func_pkg::pin_codes_t  pin_code;
	pin_func_pkg::pin_vec_t    want;
	pin_func_pkg::pin_vec_t    pin_wire;
	pin_func_pkg::ctrl_vec_t   ctrl_sw;
	logic [35:0]               src;
	pin_func_pkg::ctrl_vec_t   ctrl;
	pin_func_pkg::pin_vec_t    drive;
	pin_func_pkg::pin_vec_t    oe;
	int                        miscompares;
	int                        n_compared;

	// ==========================================
	// Clock, design and board
	always #2 clk_in = ~clk_in;

	pin_func_decode DUT (
		.clk_in          (clk_in),
		.rstn_in         (rstn_in),
		.ce_in           (ce_in),
		.pin_mode_in     (pin_mode),
		.pin_code_in     (pin_code),
		.pin_level_in    (pin_wire),
		.ctrl_sw_in      (ctrl_sw),
		.loop1_lock_in   (src[3:0]),
		.loop1_active_in (src[9:4]),
		.loop1_mode_in   (src[12:10]),
		.loop1_hist_in   (src[18:13]),
		.dist1_slew_in   (src[22:19]),
		.dist1_err_in    (src[26:23]),
		.aux_clk_in      (src[30:27]),
		.aux_loop_in     (src[32:31]),
		.meas_event_in   (src[35:33]),
		.ctrl_out        (ctrl),
		.pin_drive_out   (drive),
		.pin_oe_out      (oe)
	);

	board_model board (
		.want_in  (want),
		.drive_in (drive),
		.oe_in    (oe),
		.wire_out (pin_wire)
	);

	// ==========================================
	// Expected values
	function automatic int ctrl_idx(input int c);
		if (c == 'h47) return 0;
		if (c >= 'h50 && c <= 'h5b) return c - 'h50 + 1;
		if (c >= 'h60 && c <= 'h67) return c - 'h60 + 13;
		if (c >= 'h70 && c <= 'h78) return c - 'h70 + 21;
		return -1;
	endfunction

	function automatic logic exp_stat(input int c, input logic [35:0] s);
		if (c >= 'h50 && c <= 'h53) return s[c - 'h50];
		if (c == 'h54) return |s[9:4];
		if (c >= 'h55 && c <= 'h57) return s[c - 'h55 + 10];
		if (c == 'h58) return s[13];
		if (c == 'h5a) return s[14];
		if (c == 'h5b) return s[15];
		if (c == 'h5f) return s[17];
		if (c == 'h60) return s[18];
		if (c == 'h62) return |s[22:19];
		if (c == 'h63) return |s[26:23];
		if (c >= 'h70 && c <= 'h73) return s[c - 'h70 + 27];
		if (c >= 'h74 && c <= 'h75) return s[c - 'h74 + 31];
		if (c >= 'h78 && c <= 'h7a) return s[c - 'h78 + 33];
		return 1'b0;
	endfunction

	task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
			miscompares++;
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	// ==========================================
	// Scenarios
	// Every mapped control code on every pin in turn, with the sync latency
	task automatic t_ctrl_map();
		int c;
		int p;
		pin_func_pkg::pin_codes_t pc;
		logic [35:0] e;
		for (c = 'h47; c <= 'h7f; c++) begin
			for (p = 0; p < 4; p++) begin
				if (ctrl_idx(c) < 0) continue;
				pc = {4{7'h48}};
				pc[p] = 7'(c);
				e = 36'h1 << ctrl_idx(c);
				@(posedge clk_in);
				pin_mode <= 4'hf ^ (4'h1 << p);
				pin_code <= pc;
				want <= 4'h0;
				ctrl_sw <= 30'h0;
				step(4);
				check(36'(ctrl), 36'h0, "ctrl idle");
				@(posedge clk_in);
				want[p] <= 1'b1;
				step(2);
				check(36'(ctrl), 36'h0, "ctrl too early");
				step(1);
				check(36'(ctrl), e, "ctrl map");
			end
		end
		$display("test ctrl_map done");
	endtask

	// Unassigned codes on every pin leave the software values untouched
	task automatic t_ctrl_unassigned();
		int c;
		for (c = 'h47; c <= 'h7f; c++) begin
			if (ctrl_idx(c) < 0) begin
				@(posedge clk_in);
				pin_mode <= (c % 2 == 1) ? 4'he : 4'h0;
				pin_code <= {4{7'(c)}};
				want <= 4'hf;
				ctrl_sw <= 30'h2aaaaaaa;
				step(5);
				check(36'(ctrl), 36'h2aaaaaaa, "unassigned ctrl");
			end
		end
		$display("test ctrl_unassigned done");
	endtask

	// Two control pins on one bit, a status pin with the same code is ignored
	task automatic t_ctrl_pairing();
		@(posedge clk_in);
		pin_mode <= 4'b0100;
		pin_code <= {7'h7f, 7'h59, 7'h59, 7'h59};
		ctrl_sw <= 30'h3fffffff;
		want <= 4'b1100;
		step(5);
		check(36'(ctrl), 36'h3ffffbff, "pin overrides sw");
		@(posedge clk_in);
		want <= 4'b0010;
		step(4);
		check(36'(ctrl), 36'h3fffffff, "or of pins");
		@(posedge clk_in);
		want <= 4'b0000;
		step(4);
		check(36'(ctrl), 36'h3ffffbff, "both pins low");
		$display("test ctrl_pairing done");
	endtask

	// Clock enable low holds the synchroniser
	task automatic t_freeze();
		@(posedge clk_in);
		pin_mode <= 4'h0;
		pin_code <= {{3{7'h48}}, 7'h61};
		ctrl_sw <= 30'h0;
		want <= 4'h0;
		step(4);
		@(posedge clk_in);
		ce_in <= 1'b0;
		want <= 4'h1;
		step(6);
		check(36'(ctrl), 36'h0, "frozen");
		@(posedge clk_in);
		ce_in <= 1'b1;
		step(3);
		check(36'(ctrl), 36'h1 << 14, "after enable");
		$display("test freeze done");
	endtask

	// Every status code on all pins, walking one source bit at a time
	task automatic t_status();
		int c;
		int k;
		logic [35:0] s;
		logic [7:0]  e;
		for (c = 'h47; c <= 'h7f; c++) begin
			for (k = -1; k < 36; k++) begin
				s = (k < 0) ? 36'h0 : (36'h1 << k);
				e = {4'hf, {4{exp_stat(c, s)}}};
				@(posedge clk_in);
				pin_mode <= 4'hf;
				pin_code <= {4{7'(c)}};
				src <= s;
				step(2);
				check({oe, drive}, e, "status pin");
			end
		end
		$display("test status done");
	endtask

	// Reset in mid-run clears every output; they return three edges after release
	task automatic t_reset();
		@(posedge clk_in);
		pin_mode <= 4'hf;
		pin_code <= {4{7'h50}};
		src <= 36'h1;
		ctrl_sw <= 30'h3fffffff;
		step(2);
		check(36'(ctrl), 36'h3fffffff, "ctrl before reset");
		check({oe, drive}, 8'hff, "pins before reset");
		@(posedge clk_in);
		rstn_in <= 1'b0;
		#1;
		check(36'(ctrl), 36'h0, "ctrl in reset");
		check({oe, drive}, 8'h00, "pins in reset");
		step(3);
		@(posedge clk_in);
		rstn_in <= 1'b1;
		step(2);
		check(36'(ctrl), 36'h0, "ctrl held after release");
		check({oe, drive}, 8'h00, "pins held after release");
		step(1);
		check(36'(ctrl), 36'h3fffffff, "ctrl after reset");
		check({oe, drive}, 8'hff, "pins after reset");
		$display("test reset done");
	endtask

	// ==========================================
	// Verdict and watchdog
	task automatic give_verdict();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		#(40000 * 4);
		miscompares++;
		give_verdict();
	end

	initial begin
		clk_in = 1'b0;
		rstn_in = 1'b0;
		ce_in = 1'b1;
		pin_mode = 4'h0;
		pin_code = {4{7'h48}};
		want = 4'h0;
		ctrl_sw = 30'h0;
		src = 36'h0;
		miscompares = 0;
		n_compared = 0;
		repeat (4) @(posedge clk_in);
		rstn_in <= 1'b1;
		step(5);
		t_ctrl_map();
		t_ctrl_unassigned();
		t_ctrl_pairing();
		t_freeze();
		t_status();
		t_reset();
		give_verdict();
	end
endmodule
